// >>> logic/afp_core.sv
// alu flag register, accumulator, product registers and apb slave
`timescale 1ns/1ps
`default_nettype none
`include "afp_consts.svh"

module afp_core (
   // clock and reset
   input  wire  logic                  pclk,
   input  wire  logic                  presetn,
   // apb slave
   input  wire  afp_pkg::afp_apb_req_s apb_req,
   output logic [31:0]                 prdata_q,
   output logic                        pready_q,
   output logic                        pslverr_q,
   // instruction from the decoder
   input  wire  afp_pkg::afp_instr_s   instr,
   // results toward the core
   output afp_pkg::afp_ext_wr_s        file_wr_q,
   output logic [7:0]                  acc_q,
   output logic [7:0]                  flags_q,
   output afp_pkg::afp_step_e          step_a_q,
   output afp_pkg::afp_step_e          step_b_q
);
   import afp_pkg::*;

   // byte address match for a register index
   function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
      return addr == {2'b00, idx, 2'b00};
   endfunction : reg_hit

   // step field decode
   function automatic afp_step_e step_dec(input logic [1:0] f);
      logic [1:0] c;
      c = f;
      if (c[1]) begin
         return AFP_STEP_HOLD;
      end else if (c[0]) begin
         return AFP_STEP_INC;
      end else begin
         return AFP_STEP_DEC;
      end
   endfunction : step_dec

   // internal registers and decode
   logic [7:0]   product_low_byte_q;
   logic [7:0]   product_high_byte_q;
   logic [7:0]   flags_d;
   logic [7:0]   file_opnd;
   logic [7:0]   opnd;
   logic         two_op;
   logic         exec;
   logic         to_file;
   logic         apb_setup;
   logic         apb_wr;
   logic         apb_mapped;
   logic [7:0]   apb_rbyte;
   logic         wr_flags_apb;
   logic         wr_acc_apb;
   logic         wr_product_low_byte_apb;
   logic         wr_product_high_byte_apb;
   afp_alu_out_s y;

   // destination strobes and apb address hits
   logic         wr_dst_file;
   logic         wr_dst_acc;
   logic         wr_dst_flags;
   logic         wr_dst_product_low_byte;
   logic         wr_dst_product_high_byte;
   logic         wr_dst_ext;
   logic         hit_flags;
   logic         hit_acc;
   logic         hit_product_low_byte;
   logic         hit_product_high_byte;

   // instruction valid and two-operand class
   always_comb begin
      exec = instr.valid;
      unique case (instr.op)
         AFP_OP_ADD,
         AFP_OP_ADDC,
         AFP_OP_SUB,
         AFP_OP_SUBB,
         AFP_OP_AND,
         AFP_OP_IOR,
         AFP_OP_XOR,
         AFP_OP_MOV,
         AFP_OP_MUL: two_op = 1'b1;
         default:    two_op = 1'b0;
      endcase
   end

   // destination side: move-to-file always writes a file register
   always_comb begin
      to_file = (instr.op == AFP_OP_MOVE_ACC_TO_FILE_OP) ? 1'b1 : ~instr.dest_acc;
   end

   // file register operand select
   always_comb begin
      unique case (instr.file_sel)
         AFP_FILE_EXT:   file_opnd = instr.file_data;
         AFP_FILE_FLAGS: file_opnd = flags_q;
         AFP_FILE_PRODUCT_LOW_BYTE: file_opnd = product_low_byte_q;
         AFP_FILE_PRODUCT_HIGH_BYTE: file_opnd = product_high_byte_q;
      endcase
   end

   // alu operand select
   always_comb begin
      if (two_op) begin
         opnd = instr.use_literal ? instr.literal : file_opnd;
      end else begin
         opnd = instr.single_from_acc ? acc_q : file_opnd;
      end
   end

   // datapath; accumulator always feeds the second port
   afp_alu u_alu (
      .op      (instr.op),
      .opnd    (opnd),
      .acc     (acc_q),
      .cin     (flags_q[`AFP_BIT_C]),
      .bit_sel (instr.bit_sel),
      .y       (y)
   );

   // result destinations of an executing instruction
   always_comb begin
      wr_dst_file  = exec & y.wr_result & to_file;
      wr_dst_acc   = exec & y.wr_result & ~to_file;
      wr_dst_flags = wr_dst_file & (instr.file_sel == AFP_FILE_FLAGS);
      wr_dst_product_low_byte = wr_dst_file & (instr.file_sel == AFP_FILE_PRODUCT_LOW_BYTE);
      wr_dst_product_high_byte = wr_dst_file & (instr.file_sel == AFP_FILE_PRODUCT_HIGH_BYTE);
      wr_dst_ext   = wr_dst_file & (instr.file_sel == AFP_FILE_EXT);
   end

   // apb address decode, one hit per register
   always_comb begin
      hit_flags = reg_hit(apb_req.paddr, `AFP_IDX_FLAGS);
      hit_acc   = reg_hit(apb_req.paddr, `AFP_IDX_ACC);
      hit_product_low_byte = reg_hit(apb_req.paddr, `AFP_IDX_PRODUCT_LOW_BYTE);
      hit_product_high_byte = reg_hit(apb_req.paddr, `AFP_IDX_PRODUCT_HIGH_BYTE);
   end

   // apb phase, write strobes and read byte
   always_comb begin
      apb_setup    = apb_req.psel & ~apb_req.penable;
      apb_wr       = apb_req.psel & apb_req.penable & pready_q &
                     apb_req.pwrite & apb_req.pstrb[0];
      wr_flags_apb = apb_wr & hit_flags;
      wr_acc_apb   = apb_wr & hit_acc;
      wr_product_low_byte_apb = apb_wr & hit_product_low_byte;
      wr_product_high_byte_apb = apb_wr & hit_product_high_byte;
      apb_mapped   = hit_flags | hit_acc | hit_product_low_byte | hit_product_high_byte;
      apb_rbyte    = `AFP_BYTE_RST;
      if (hit_flags) begin
         apb_rbyte = flags_q;
      end else if (hit_acc) begin
         apb_rbyte = acc_q;
      end else if (hit_product_low_byte) begin
         apb_rbyte = product_low_byte_q;
      end else if (hit_product_high_byte) begin
         apb_rbyte = product_high_byte_q;
      end
   end

   // flag register next value; instruction wins over apb
   always_comb begin
      flags_d = flags_q;
      // an apb write lands first
      if (wr_flags_apb) begin
         flags_d = apb_req.pwdata[7:0];
      end
      // an executing instruction overrides it; affected status bits from flag logic
      if (exec) begin
         for (int i = 0; i <= `AFP_STATUS_HI; i++) begin
            if (y.affect[i]) begin
               flags_d[i] = y.flags[i];
            end
         end
         if (wr_dst_flags) begin
            if (|y.affect[`AFP_BIT_Z:`AFP_BIT_C]) begin
               // status nibble blocked, control nibble written
               flags_d[`AFP_STEP_B_HI:`AFP_CTRL_LO] =
                  y.result[`AFP_STEP_B_HI:`AFP_CTRL_LO];
            end else begin
               flags_d = y.result;
            end
         end
      end
   end

   // flag register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= `AFP_FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   // decoded step modes follow the next flag value, so they match flags_q
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_a_q <= AFP_STEP_HOLD;
         step_b_q <= AFP_STEP_HOLD;
      end else begin
         step_a_q <= step_dec(flags_d[`AFP_STEP_A_HI:`AFP_STEP_A_LO]);
         step_b_q <= step_dec(flags_d[`AFP_STEP_B_HI:`AFP_STEP_B_LO]);
      end
   end

   // working accumulator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= `AFP_BYTE_RST;
      end else if (wr_dst_acc) begin
         acc_q <= y.result;
      end else if (wr_acc_apb) begin
         acc_q <= apb_req.pwdata[7:0];
      end
   end

   // product low byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         product_low_byte_q <= `AFP_BYTE_RST;
      end else if (exec && y.wr_prod) begin
         product_low_byte_q <= y.product[7:0];
      end else if (wr_dst_product_low_byte) begin
         product_low_byte_q <= y.result;
      end else if (wr_product_low_byte_apb) begin
         product_low_byte_q <= apb_req.pwdata[7:0];
      end
   end

   // product high byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         product_high_byte_q <= `AFP_BYTE_RST;
      end else if (exec && y.wr_prod) begin
         product_high_byte_q <= y.product[15:8];
      end else if (wr_dst_product_high_byte) begin
         product_high_byte_q <= y.result;
      end else if (wr_product_high_byte_apb) begin
         product_high_byte_q <= apb_req.pwdata[7:0];
      end
   end

   // write toward external file register, one-cycle pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         file_wr_q <= '0;
      end else begin
         file_wr_q.valid <= wr_dst_ext;
         file_wr_q.data  <= y.result;
      end
   end

   // apb ready: one cycle, the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= apb_setup;
      end
   end

   // apb error alongside ready for an address with no register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_q <= 1'b0;
      end else begin
         pslverr_q <= apb_setup & ~apb_mapped;
      end
   end

   // apb read data captured at the setup edge, held until the next setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= `AFP_WORD_ZERO;
      end else if (apb_setup) begin
         prdata_q <= {24'h000000, apb_rbyte};
      end
   end

endmodule : afp_core
`default_nettype wire

// >>> pkg/afp_consts.svh
// register offsets, field positions and reset values of the alu flag block
`ifndef AFP_CONSTS_SVH
`define AFP_CONSTS_SVH

// register indices; byte address is four times the index
`define AFP_IDX_FLAGS    8'h04
`define AFP_IDX_ACC      8'h0a
`define AFP_IDX_PRODUCT_LOW_BYTE    8'h18
`define AFP_IDX_PRODUCT_HIGH_BYTE    8'h19

// flag register fields
`define AFP_BIT_C        0
`define AFP_BIT_DC       1
`define AFP_BIT_Z        2
`define AFP_BIT_OV       3
`define AFP_STEP_A_LO    4
`define AFP_STEP_A_HI    5
`define AFP_STEP_B_LO    6
`define AFP_STEP_B_HI    7
`define AFP_STATUS_HI    3
`define AFP_CTRL_LO      4

// reset values
`define AFP_FLAGS_RST    8'hf0
`define AFP_BYTE_RST     8'h00
`define AFP_WORD_ZERO    32'h0000_0000

// arithmetic constants
`define AFP_ONE          8'h01
`define AFP_ALL_ONES     8'hff
`define AFP_ZERO_BYTE    8'h00
`define AFP_MSB          7
`define AFP_NIB_CARRY    4

`endif

// >>> pkg/afp_pkg.sv
// types shared by the alu flag block and its datapath
package afp_pkg;

   // alu operations
   typedef enum logic [4:0] {
      AFP_OP_ADD     = 5'b00000,
      AFP_OP_ADDC    = 5'b00001,
      AFP_OP_SUB     = 5'b00010,
      AFP_OP_SUBB    = 5'b00011,
      AFP_OP_AND     = 5'b00100,
      AFP_OP_IOR     = 5'b00101,
      AFP_OP_XOR     = 5'b00110,
      AFP_OP_COM     = 5'b00111,
      AFP_OP_INC     = 5'b01000,
      AFP_OP_DEC     = 5'b01001,
      AFP_OP_NEG     = 5'b01010,
      AFP_OP_RLC     = 5'b01011,
      AFP_OP_RRC     = 5'b01100,
      AFP_OP_RL      = 5'b01101,
      AFP_OP_RR      = 5'b01110,
      AFP_OP_SWAP    = 5'b01111,
      AFP_OP_CLR     = 5'b10000,
      AFP_OP_MOV     = 5'b10001,
      AFP_OP_MOVE_ACC_TO_FILE_OP   = 5'b10010,
      AFP_OP_BCLR    = 5'b10011,
      AFP_OP_BSET    = 5'b10100,
      AFP_OP_MUL     = 5'b10101
   } afp_op_e;

   // decoded pointer step mode
   typedef enum logic [1:0] {
      AFP_STEP_DEC  = 2'b00,
      AFP_STEP_INC  = 2'b01,
      AFP_STEP_HOLD = 2'b10
   } afp_step_e;

   // file operand / destination select
   typedef enum logic [1:0] {
      AFP_FILE_EXT   = 2'b00,
      AFP_FILE_FLAGS = 2'b01,
      AFP_FILE_PRODUCT_LOW_BYTE = 2'b10,
      AFP_FILE_PRODUCT_HIGH_BYTE = 2'b11
   } afp_file_e;

   // one instruction from the decoder
   typedef struct packed {
      logic       valid;
      afp_op_e    op;
      logic       use_literal;
      logic       single_from_acc;
      logic       dest_acc;
      afp_file_e  file_sel;
      logic [2:0] bit_sel;
      logic [7:0] file_data;
      logic [7:0] literal;
   } afp_instr_s;

   // apb request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } afp_apb_req_s;

   // datapath answer; flags and affect use flag register bit order
   typedef struct packed {
      logic [7:0]  result;
      logic [3:0]  flags;
      logic [3:0]  affect;
      logic        wr_result;
      logic        wr_prod;
      logic [15:0] product;
   } afp_alu_out_s;

   // write toward an external file register
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } afp_ext_wr_s;

endpackage : afp_pkg

// >>> logic/afp_alu.sv
// combinational datapath: result, status flags and product
`timescale 1ns/1ps
`default_nettype none
`include "afp_consts.svh"

module afp_alu (
   // operation and operands
   input  wire afp_pkg::afp_op_e     op,
   input  wire logic [7:0]           opnd,
   input  wire logic [7:0]           acc,
   input  wire logic                 cin,
   input  wire logic [2:0]           bit_sel,
   // answer
   output var  afp_pkg::afp_alu_out_s y
);
   import afp_pkg::*;

   // add with carry in; returns {ov, dc, c, sum}
   function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                         input logic ci);
      logic [8:0] s;
      logic [4:0] n;
      logic       ov;
      s  = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      n  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      ov = (a[`AFP_MSB] == b[`AFP_MSB]) && (s[`AFP_MSB] != a[`AFP_MSB]);
      return {ov, n[`AFP_NIB_CARRY], s[8], s[7:0]};
   endfunction : add8

   logic [10:0] ar;
   logic        c_new;

   // operation select and flag effects
   always_comb begin
      ar        = 11'h000;
      c_new     = cin;
      y         = '0;
      y.wr_result = 1'b1;
      y.product = {8'h00, opnd} * {8'h00, acc};
      unique case (op)
         AFP_OP_ADD:  ar = add8(opnd, acc, 1'b0);
         AFP_OP_ADDC: ar = add8(opnd, acc, cin);
         AFP_OP_SUB:  ar = add8(opnd, ~acc, 1'b1);
         AFP_OP_SUBB: ar = add8(opnd, ~acc, cin);
         AFP_OP_INC:  ar = add8(opnd, `AFP_ONE, 1'b0);
         AFP_OP_DEC:  ar = add8(opnd, `AFP_ALL_ONES, 1'b0);
         AFP_OP_NEG:  ar = add8(~opnd, `AFP_ZERO_BYTE, 1'b1);
         default:     ar = 11'h000;
      endcase
      unique case (op)
         AFP_OP_ADD, AFP_OP_ADDC, AFP_OP_SUB, AFP_OP_SUBB,
         AFP_OP_INC, AFP_OP_DEC, AFP_OP_NEG: begin
            y.result = ar[7:0];
            c_new    = ar[8];
            y.affect = 4'hf;
         end
         AFP_OP_AND:   begin y.result = opnd & acc;  y.affect = 4'h4; end
         AFP_OP_IOR:   begin y.result = opnd | acc;  y.affect = 4'h4; end
         AFP_OP_XOR:   begin y.result = opnd ^ acc;  y.affect = 4'h4; end
         AFP_OP_COM:   begin y.result = ~opnd;       y.affect = 4'h4; end
         AFP_OP_CLR:   begin y.result = `AFP_ZERO_BYTE; y.affect = 4'h4; end
         AFP_OP_MOV:   begin y.result = opnd;        y.affect = 4'h4; end
         AFP_OP_RLC: begin
            y.result = {opnd[6:0], cin};
            c_new    = opnd[`AFP_MSB];
            y.affect = 4'h1;
         end
         AFP_OP_RRC: begin
            y.result = {cin, opnd[7:1]};
            c_new    = opnd[0];
            y.affect = 4'h1;
         end
         AFP_OP_RL:    y.result = {opnd[6:0], opnd[`AFP_MSB]};
         AFP_OP_RR:    y.result = {opnd[0], opnd[7:1]};
         AFP_OP_SWAP:  y.result = {opnd[3:0], opnd[7:4]};
         AFP_OP_MOVE_ACC_TO_FILE_OP: y.result = acc;
         AFP_OP_BCLR:  y.result = opnd & ~(`AFP_ONE << bit_sel);
         AFP_OP_BSET:  y.result = opnd | (`AFP_ONE << bit_sel);
         AFP_OP_MUL: begin
            y.wr_result = 1'b0;
            y.wr_prod   = 1'b1;
         end
         default:      y.wr_result = 1'b0;
      endcase
      y.flags[`AFP_BIT_OV] = ar[10];
      y.flags[`AFP_BIT_DC] = ar[9];
      y.flags[`AFP_BIT_C]  = c_new;
      y.flags[`AFP_BIT_Z]  = (y.result == `AFP_ZERO_BYTE);
   end

endmodule : afp_alu
`default_nettype wire

// >>> bench/afp_file_model.sv
// file register on the data bus beside the alu block
`timescale 1ns/1ps
`default_nettype none

module afp_file_model (
   // clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // write from the block, value back to the decoder
   input  wire afp_pkg::afp_ext_wr_s file_wr,
   output logic [7:0]              file_data
);
   import afp_pkg::*;

   // holds the last byte written; decoder feeds it back as a file operand
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         file_data <= 8'h3c;
      end else if (file_wr.valid) begin
         file_data <= file_wr.data;
      end
   end
endmodule : afp_file_model
`default_nettype wire

// >>> bench/afp_core_monitor.sv
// concurrent checks on the ports of the alu flag block
`timescale 1ns/1ps
`default_nettype none

module afp_core_monitor (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // observed ports
   input  wire afp_pkg::afp_apb_req_s apb_req,
   input  wire logic [31:0]           prdata_q,
   input  wire logic                  pready_q,
   input  wire logic                  pslverr_q,
   input  wire afp_pkg::afp_instr_s   instr,
   input  wire afp_pkg::afp_ext_wr_s  file_wr_q,
   input  wire logic [7:0]            acc_q,
   input  wire logic [7:0]            flags_q,
   input  wire afp_pkg::afp_step_e    step_a_q,
   input  wire afp_pkg::afp_step_e    step_b_q
);
   import afp_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // literal plus accumulator with carry out
   logic [8:0] lit_sum;
   logic       add_lit;
   assign lit_sum = {1'b0, instr.literal} + {1'b0, acc_q};
   assign add_lit = instr.valid && instr.op == AFP_OP_ADD && instr.use_literal;

   add_sum_a: assert property (add_lit && instr.dest_acc |=> acc_q == $past(lit_sum[7:0]))
      else $error("accumulator sum wrong");
   add_zero_a: assert property (add_lit && instr.dest_acc |=> flags_q[2] == (acc_q == 8'h00))
      else $error("zero flag wrong");
   add_carry_a: assert property (add_lit && instr.dest_acc |=> flags_q[0] == $past(lit_sum[8]))
      else $error("carry flag wrong");
   flag_override_a: assert property (add_lit && !instr.dest_acc && instr.file_sel == AFP_FILE_FLAGS
      |=> flags_q[7:4] == $past(lit_sum[7:4]) && flags_q[0] == $past(lit_sum[8]))
      else $error("flag write override wrong");
   clr_flags_a: assert property (instr.valid && instr.op == AFP_OP_CLR && !instr.dest_acc
      && instr.file_sel == AFP_FILE_FLAGS
      |=> flags_q == {4'h0, $past(flags_q[3]), 1'b1, $past(flags_q[1:0])})
      else $error("cleared flag pattern wrong");
   rlc_carry_a: assert property (instr.valid && instr.op == AFP_OP_RLC && instr.single_from_acc
      |=> flags_q[0] == $past(acc_q[7]))
      else $error("rotate carry wrong");
   move_acc_to_file_op_out_a: assert property (instr.valid && instr.op == AFP_OP_MOVE_ACC_TO_FILE_OP
      && instr.file_sel == AFP_FILE_EXT
      |=> file_wr_q.valid && file_wr_q.data == $past(acc_q))
      else $error("file write of accumulator wrong");
   step_a_dec_a: assert property (step_a_q == (flags_q[5] ? AFP_STEP_HOLD
      : (flags_q[4] ? AFP_STEP_INC : AFP_STEP_DEC)))
      else $error("pointer a step decode wrong");
   step_b_dec_a: assert property (step_b_q == (flags_q[7] ? AFP_STEP_HOLD
      : (flags_q[6] ? AFP_STEP_INC : AFP_STEP_DEC)))
      else $error("pointer b step decode wrong");
   ready_pulse_a: assert property (apb_req.psel && !apb_req.penable |=> pready_q ##1 !pready_q)
      else $error("bus ready timing wrong");
endmodule : afp_core_monitor
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the alu flag block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import afp_pkg::*;
   typedef struct {afp_op_e op; logic [7:0] lit; logic [7:0] acc; logic [7:0] res;
      logic [3:0] nib;} afp_row_s;
   // op, literal, accumulator in, accumulator out, status nibble out
   afp_row_s rows [8] = '{
      '{AFP_OP_ADD, 8'h01, 8'hff, 8'h00, 4'h7}, '{AFP_OP_ADD, 8'h01, 8'h7f, 8'h80, 4'ha},
      '{AFP_OP_SUB, 8'h05, 8'h03, 8'h02, 4'h3}, '{AFP_OP_SUB, 8'h03, 8'h05, 8'hfe, 4'h0},
      '{AFP_OP_SUB, 8'h80, 8'h01, 8'h7f, 4'h9}, '{AFP_OP_AND, 8'h0f, 8'hf0, 8'h00, 4'h4},
      '{AFP_OP_RLC, 8'h00, 8'h81, 8'h02, 4'h1}, '{AFP_OP_INC, 8'h00, 8'hff, 8'h00, 4'h7}};
   logic         pclk;
   logic         presetn;
   afp_apb_req_s apb_req;
   logic [31:0]  prdata_q;
   logic         pready_q;
   logic         pslverr_q;
   afp_instr_s   ins;
   afp_instr_s   instr;
   afp_ext_wr_s  file_wr_q;
   logic [7:0]   acc_q;
   logic [7:0]   flags_q;
   afp_step_e    step_a_q;
   afp_step_e    step_b_q;
   logic [7:0]   ext_data;
   logic [31:0]  rd;
   logic         err;
   int           fails;
   int           num_checks;
   int           cyc;

   // the file operand comes back from the file register model
   always_comb begin
      instr = ins;
      instr.file_data = ext_data;
   end
   afp_core uut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata_q(prdata_q),
      .pready_q(pready_q), .pslverr_q(pslverr_q), .instr(instr), .file_wr_q(file_wr_q),
      .acc_q(acc_q), .flags_q(flags_q), .step_a_q(step_a_q), .step_b_q(step_b_q));
   afp_file_model u_file (.pclk(pclk), .presetn(presetn), .file_wr(file_wr_q),
      .file_data(ext_data));

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict
   // one apb transfer; waits for pready, only the cycle ceiling ends the wait
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d, pstrb: s};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      @(posedge pclk);
      while (pready_q !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata_q;
      err = pslverr_q;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      @(negedge pclk);
   endtask : apb
   task automatic exec(input afp_op_e op, input logic ul, input logic [7:0] lit,
      input logic dacc, input afp_file_e fs);
      @(posedge pclk);
      ins <= '{valid: 1'b1, op: op, use_literal: ul, single_from_acc: 1'b1, dest_acc: dacc,
         file_sel: fs, bit_sel: 3'h0, file_data: 8'h00, literal: lit};
      @(posedge pclk);
      ins.valid <= 1'b0;
      @(negedge pclk);
   endtask : exec
   task automatic done(input string name);
      $display("test %s finished", name);
   endtask : done

   // 50 ns clock and cycle ceiling
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fails++;
         print_verdict();
      end
   end

   initial begin
      fails = 0;
      num_checks = 0;
      presetn = 1'b0;
      apb_req = '0;
      ins = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      // reset values
      apb(1'b0, 12'h010, 32'h0, 4'h1);
      check("flags reset", 32'h0000_00f0, rd);
      check("step a reset", AFP_STEP_HOLD, step_a_q);
      apb(1'b0, 12'h060, 32'h0, 4'h1);
      check("product low reset", 32'h0, rd);
      done("reset");
      // table of operations, result to accumulator
      foreach (rows[i]) begin
         apb(1'b1, 12'h010, 32'h0, 4'h1);
         apb(1'b1, 12'h028, {24'h0, rows[i].acc}, 4'h1);
         exec(rows[i].op, 1'b1, rows[i].lit, 1'b1, AFP_FILE_EXT);
         apb(1'b0, 12'h028, 32'h0, 4'h1);
         check("acc", {24'h0, rows[i].res}, rd);
         apb(1'b0, 12'h010, 32'h0, 4'h1);
         check("flags", {28'h0, rows[i].nib}, rd);
      end
      done("table");
      // step mode codes on both pointers
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, 12'h010, {24'h0, 2'(c), 2'(c), 4'h0}, 4'h1);
         check("step a", c == 0 ? AFP_STEP_DEC : c == 1 ? AFP_STEP_INC : AFP_STEP_HOLD,
            step_a_q);
         check("step b", c == 0 ? AFP_STEP_DEC : c == 1 ? AFP_STEP_INC : AFP_STEP_HOLD,
            step_b_q);
      end
      done("step modes");
      // add into the flag register: data upper nibble, logic lower
      apb(1'b1, 12'h028, 32'h1f, 4'h1);
      exec(AFP_OP_ADD, 1'b1, 8'h01, 1'b0, AFP_FILE_FLAGS);
      check("flags dest", 32'h22, {24'h0, flags_q});
      check("step a hold", AFP_STEP_HOLD, step_a_q);
      apb(1'b1, 12'h010, 32'hf9, 4'h1);
      exec(AFP_OP_CLR, 1'b0, 8'h00, 1'b0, AFP_FILE_FLAGS);
      check("flags cleared", 32'h0d, {24'h0, flags_q});
      done("flag destination");
      // multiply once into both product bytes, then product registers
      apb(1'b1, 12'h028, 32'hff, 4'h1);
      exec(AFP_OP_MUL, 1'b1, 8'hff, 1'b1, AFP_FILE_EXT);
      apb(1'b0, 12'h060, 32'h0, 4'h1);
      check("product low", 32'h01, rd);
      apb(1'b0, 12'h064, 32'h0, 4'h1);
      check("product high", 32'hfe, rd);
      done("multiply");
      // accumulator to file, then file as first operand
      apb(1'b1, 12'h028, 32'h5a, 4'h1);
      exec(AFP_OP_MOVE_ACC_TO_FILE_OP, 1'b0, 8'h00, 1'b0, AFP_FILE_EXT);
      exec(AFP_OP_ADD, 1'b0, 8'h00, 1'b1, AFP_FILE_EXT);
      check("file plus acc", 32'hb4, {24'h0, acc_q});
      done("file operand");
      // refused accesses
      apb(1'b0, 12'h100, 32'h0, 4'h1);
      check("unmapped error", 32'h1, {31'h0, err});
      check("unmapped data", 32'h0, rd);
      apb(1'b1, 12'h028, 32'h11, 4'h0);
      check("masked write", 32'hb4, {24'h0, acc_q});
      done("refused");
      // reset in mid-run returns the registers to their reset values
      @(posedge pclk);
      presetn <= 1'b0;
      @(negedge pclk);
      check("acc in reset", 32'h0, {24'h0, acc_q});
      check("flags in reset", 32'hf0, {24'h0, flags_q});
      check("step b in reset", AFP_STEP_HOLD, step_b_q);
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h064, 32'h0, 4'h1);
      check("product high after reset", 32'h0, rd);
      done("reset mid-run");
      print_verdict();
   end
endmodule : tb_top

// port checker bound into every instance of the block
bind afp_core afp_core_monitor u_mon (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
   .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .instr(instr),
   .file_wr_q(file_wr_q), .acc_q(acc_q), .flags_q(flags_q), .step_a_q(step_a_q),
   .step_b_q(step_b_q));
`default_nettype wire
